// ### design/pcc_pkg.sv
// Constants for the PLL and module clock divider configuration block
// Overview of operation
// - The top bit of the PLL setup register must be set in a write for a new multiplier to load.
// - The PLL setup register holds the fraction in bits 23:16 and the integer in bits 15:8.
// - PLL output equals reference times the integer plus fraction, over a fixed pre-divide of 4.
// - After a PLL change, reset is held for none, 0x100, 0x400 or 0xFF0 clocks per a 2-bit code.
// - The memory clock is the core clock over 2, 4 or 3 for codes 00, 01 and 1x of bits 1:0.
// - The pixel divisor is bits 31:24, top bit validating seven divisor bits, zero meaning none.
// - The camera divisor is bits 23:16, resets to 0x24, top bit validating, zero meaning none.
// - The core divisor is bits 15:8, resets to 0x2, top bit validating, zero meaning none.
// - Bit 5 applies the pixel divisor and bit 3 the camera divisor; both reset to zero.
// - Pixel source select in bit 4 picks the divided PLL clock when set, else the crystal.
// - Camera source select picks the divided PLL clock when set, else the crystal.
// - Core source select picks the divided PLL clock when set, else the crystal, with an apply flag.
// - Pixel, camera and core clocks equal their selected source clock over their seven-bit divisors.
package pcc_pkg;
  localparam int          DATA_W        = 32;
  localparam int          ADDR_W        = 32;
  localparam int          SEL_W         = 4;
  // Register byte addresses
  localparam logic [31:0] ADDR_SETUP    = 32'hBFE78030;
  localparam logic [31:0] ADDR_DIVIDERS = 32'hBFE78034;
  localparam logic [31:0] ADDR_STATUS   = 32'hBFE78038;
  // Setup register fields
  localparam int          SU_VALID      = 31;
  localparam int          SU_FRAC_LSB   = 16;
  localparam int          SU_INT_LSB    = 8;
  localparam int          SU_RST_LSB    = 2;
  localparam int          SU_MEM_LSB    = 0;
  localparam logic [31:0] SU_WMASK      = 32'h80FFFF0F;
  localparam logic [31:0] SU_RESET      = 32'h00000000;
  localparam logic [7:0]  INT_ADVISED   = 8'h64;
  localparam int          PLL_PREDIV    = 4;
  // Divider register fields
  localparam int          DV_PIX_LSB    = 24;
  localparam int          DV_CAM_LSB    = 16;
  localparam int          DV_CORE_LSB   = 8;
  localparam int          DV_PIX_APPLY  = 5;
  localparam int          DV_PIX_SEL    = 4;
  localparam int          DV_CAM_APPLY  = 3;
  localparam int          DV_CAMERA_CLOCK_SOURCE    = 2;
  localparam int          DV_CORE_APPLY = 1;
  localparam int          DV_CORE_SEL   = 0;
  localparam int          DV_FIELD_VLD  = 7;
  localparam logic [31:0] DV_WMASK      = 32'hFFFFFF3F;
  localparam logic [31:0] DV_RESET      = 32'h00240200;
  localparam logic [6:0]  PIX_DIV_RST   = 7'h00;
  localparam logic [6:0]  CAMERA_CLOCK_DIVISOR_RST   = 7'h24;
  localparam logic [6:0]  CORE_DIV_RST  = 7'h02;
  // Reset hold lengths in clocks
  localparam logic [11:0] HOLD_CODE1    = 12'h100;
  localparam logic [11:0] HOLD_CODE2    = 12'h400;
  localparam logic [11:0] HOLD_CODE3    = 12'hFF0;
  // Memory divide ratios
  localparam logic [6:0]  MEM_DIV_C0    = 7'h02;
  localparam logic [6:0]  MEM_DIV_C1    = 7'h04;
  localparam logic [6:0]  MEM_DIV_CX    = 7'h03;
  // PLL sequencer states, Gray from IDLE to LOCK to HOLD; both bits flip from HOLD back to IDLE
  typedef enum logic [1:0] {
    PCC_IDLE = 2'b00,
    PCC_LOCK = 2'b01,
    PCC_HOLD = 2'b11
  } pcc_state_e;
endpackage

// ### design/pcc_divider.sv
// Glitch-free tick divider with source select
`timescale 1ns/1ps
module pcc_divider #(
  parameter int DIV_W = 7
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             pll_tick_i,
  input  wire logic             xtal_tick_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic             sel_i,
  input  wire logic [DIV_W-1:0] rst_div_i,
  output logic                  tick_o,
  output logic [DIV_W-1:0]      cur_div_o
);
  import pcc_pkg::*;

  // Refuse a counter too narrow to hold a divisor of two
  if (DIV_W < 2) begin : g_width_check
    $error("DIV_W must be at least 2");
  end

  logic             cur_sel;
  logic [DIV_W-1:0] cnt;
  logic [DIV_W-1:0] eff_div;
  logic             src_tick;
  logic             wrap;

  // Current source and effective divisor, zero means pass through
  assign src_tick = cur_sel ? pll_tick_i : xtal_tick_i;
  assign eff_div  = (cur_div_o == '0) ? DIV_W'(1) : cur_div_o;
  assign wrap     = (cnt + DIV_W'(1)) >= eff_div;

  // Count source ticks; settings change only at a period boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt       <= '0;
      tick_o    <= 1'b0;
      cur_sel   <= 1'b0;
      cur_div_o <= rst_div_i;
    end else if (src_tick && wrap) begin
      cnt       <= '0;
      tick_o    <= 1'b1;
      cur_sel   <= sel_i;
      cur_div_o <= div_i;
    end else begin
      cnt    <= src_tick ? cnt + DIV_W'(1) : cnt;
      tick_o <= 1'b0;
    end
  end
endmodule // pcc_divider

// ### design/pcc_clock_config.sv
// PLL setup, reset hold sequencer and module clock dividers with a Wishbone slave
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
module pcc_clock_config #(
  parameter int DIV_W = 7
) (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [pcc_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [pcc_pkg::DATA_W-1:0] wb_dat_i,
  input  wire logic [pcc_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic                       wb_we_i,
  input  wire logic                       wb_cyc_i,
  input  wire logic                       wb_stb_i,
  output logic [pcc_pkg::DATA_W-1:0]      wb_dat_o,
  output logic                            wb_ack_o,
  input  wire logic                       pll_locked_i,
  input  wire logic                       pll_tick_i,
  input  wire logic                       crystal_in_tick_i,
  output logic [7:0]                      pll_int_o,
  output logic [7:0]                      pll_frac_o,
  output logic                            pll_load_o,
  output logic                            sys_reset_hold_o,
  output logic                            pix_clk_en_o,
  output logic                            cam_clk_en_o,
  output logic                            core_clk_en_o,
  output logic                            mem_clk_en_o
);
  import pcc_pkg::*;

  // Refuse divisor widths that do not match the seven-bit register fields
  if (DIV_W != 7) begin : g_width_check
    $error("Divisor fields are seven bits wide");
  end

  // Byte-lane merge of a write into a register under its writable mask
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel,
                                        input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & wmask;
    return (old_v & ~lanes) | (new_v & lanes);
  endfunction

  // Hold length for a reset time code
  function automatic logic [11:0] hold_len(input logic [1:0] code);
    unique case (code)
      2'b00: return 12'h000;
      2'b01: return HOLD_CODE1;
      2'b10: return HOLD_CODE2;
      2'b11: return HOLD_CODE3;
    endcase
  endfunction

  logic [31:0]      setup;
  logic [31:0]      dividers;
  logic [DIV_W-1:0] pix_div;
  logic [DIV_W-1:0] camera_clock_divisor;
  logic [DIV_W-1:0] core_div;
  logic             pix_sel;
  logic             camera_clock_source;
  logic             core_sel;
  logic [11:0]      hold_cnt;
  pcc_state_e       state;
  pcc_state_e       next_state;
  logic [DIV_W-1:0] pix_cur;
  logic [DIV_W-1:0] cam_cur;
  logic [DIV_W-1:0] core_cur;
  logic [DIV_W-1:0] mem_cur;
  logic             pix_tick;
  logic             cam_tick;
  logic             core_tick;
  logic             mem_tick;

  // Bus decode; writes land on the edge at which the master sees ack
  wire        req        = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        done       = wb_cyc_i & wb_stb_i & wb_ack_o;
  wire        hit_setup  = (wb_adr_i == ADDR_SETUP);
  wire        hit_div    = (wb_adr_i == ADDR_DIVIDERS);
  wire        hit_stat   = (wb_adr_i == ADDR_STATUS);
  wire        wr_setup   = done & wb_we_i & hit_setup;
  wire        wr_div     = done & wb_we_i & hit_div;
  wire [31:0] setup_new  = merge(setup, wb_dat_i, wb_sel_i, SU_WMASK);
  wire [31:0] div_new    = merge(dividers, wb_dat_i, wb_sel_i, DV_WMASK);

  // Multiplier load happens only when the valid bit is written set
  wire        mult_load  = wr_setup & setup_new[SU_VALID];
  wire [7:0]  new_frac   = setup_new[SU_FRAC_LSB +: 8];
  wire [7:0]  new_int    = setup_new[SU_INT_LSB +: 8];
  wire [1:0]  rst_code   = setup[SU_RST_LSB +: 2];
  wire [1:0]  mem_code   = setup[SU_MEM_LSB +: 2];
  wire        int_high   = pll_int_o > INT_ADVISED;

  // Divisor fields and their apply conditions
  wire [7:0]  pix_fld    = div_new[DV_PIX_LSB +: 8];
  wire [7:0]  cam_fld    = div_new[DV_CAM_LSB +: 8];
  wire [7:0]  core_fld   = div_new[DV_CORE_LSB +: 8];
  wire        pix_apply  = wr_div & div_new[DV_PIX_APPLY] & pix_fld[DV_FIELD_VLD];
  wire        cam_apply  = wr_div & div_new[DV_CAM_APPLY] & cam_fld[DV_FIELD_VLD];
  wire        core_apply = wr_div & div_new[DV_CORE_APPLY] & core_fld[DV_FIELD_VLD];

  // Memory divisor from its code
  wire [6:0]  mem_div    = (mem_code == 2'b00) ? MEM_DIV_C0 :
                           (mem_code == 2'b01) ? MEM_DIV_C1 : MEM_DIV_CX;

  // Status word
  wire [31:0] status_w   = {1'b0, pix_cur, 1'b0, cam_cur, 1'b0, core_cur,
                            1'b0, mem_cur[3:0], int_high, sys_reset_hold_o,
                            state == PCC_LOCK};

  // Read mux, unmapped reads as zero
  wire [31:0] rd_data    = hit_setup ? setup :
                           hit_div   ? dividers :
                           hit_stat  ? status_w : 32'h00000000;

  // Bus answer one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req & ~wb_we_i) ? rd_data : 32'h00000000;
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup    <= SU_RESET;
      dividers <= DV_RESET;
    end else begin
      if (wr_setup) setup <= setup_new;
      if (wr_div) dividers <= div_new;
    end
  end

  // Active multiplier driven to the PLL, which divides by its fixed pre-divide
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_int_o  <= SU_RESET[SU_INT_LSB +: 8];
      pll_frac_o <= SU_RESET[SU_FRAC_LSB +: 8];
    end else if (mult_load && state == PCC_IDLE) begin
      pll_int_o  <= new_int;
      pll_frac_o <= new_frac;
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      PCC_IDLE: if (mult_load) next_state = PCC_LOCK;
      PCC_LOCK: begin
        if (pll_locked_i && !pll_load_o) begin
          next_state = (rst_code == 2'b00) ? PCC_IDLE : PCC_HOLD;
        end
      end
      PCC_HOLD: if (hold_cnt == 12'h001) next_state = PCC_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Load strobe and reset hold counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pll_load_o       <= 1'b0;
      sys_reset_hold_o <= 1'b0;
      hold_cnt         <= 12'h000;
    end else begin
      pll_load_o <= (state == PCC_IDLE) && mult_load;
      if (state == PCC_LOCK && next_state == PCC_HOLD) begin
        hold_cnt         <= hold_len(rst_code);
        sys_reset_hold_o <= 1'b1;
      end else if (state == PCC_HOLD) begin
        hold_cnt         <= hold_cnt - 12'h001;
        sys_reset_hold_o <= (hold_cnt != 12'h001);
      end
    end
  end

  // Requested divisors and source selects
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_div  <= PIX_DIV_RST;
      camera_clock_divisor  <= CAMERA_CLOCK_DIVISOR_RST;
      core_div <= CORE_DIV_RST;
      pix_sel  <= 1'b0;
      camera_clock_source  <= 1'b0;
      core_sel <= 1'b0;
    end else if (wr_div) begin
      if (pix_apply) pix_div <= pix_fld[DIV_W-1:0];
      if (cam_apply) camera_clock_divisor <= cam_fld[DIV_W-1:0];
      if (core_apply) core_div <= core_fld[DIV_W-1:0];
      pix_sel  <= div_new[DV_PIX_SEL];
      camera_clock_source  <= div_new[DV_CAMERA_CLOCK_SOURCE];
      core_sel <= div_new[DV_CORE_SEL];
    end
  end

  // Pixel clock divider
  pcc_divider #(.DIV_W(DIV_W)) u_pix (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pll_tick_i (pll_tick_i),
    .xtal_tick_i(crystal_in_tick_i),
    .div_i      (pix_div),
    .sel_i      (pix_sel),
    .rst_div_i  (PIX_DIV_RST),
    .tick_o     (pix_tick),
    .cur_div_o  (pix_cur)
  );

  // Camera clock divider
  pcc_divider #(.DIV_W(DIV_W)) u_cam (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pll_tick_i (pll_tick_i),
    .xtal_tick_i(crystal_in_tick_i),
    .div_i      (camera_clock_divisor),
    .sel_i      (camera_clock_source),
    .rst_div_i  (CAMERA_CLOCK_DIVISOR_RST),
    .tick_o     (cam_tick),
    .cur_div_o  (cam_cur)
  );

  // Core clock divider
  pcc_divider #(.DIV_W(DIV_W)) u_core (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pll_tick_i (pll_tick_i),
    .xtal_tick_i(crystal_in_tick_i),
    .div_i      (core_div),
    .sel_i      (core_sel),
    .rst_div_i  (CORE_DIV_RST),
    .tick_o     (core_tick),
    .cur_div_o  (core_cur)
  );

  // Memory clock divider fed from the core ticks
  pcc_divider #(.DIV_W(DIV_W)) u_mem (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .pll_tick_i (core_tick),
    .xtal_tick_i(core_tick),
    .div_i      (mem_div),
    .sel_i      (1'b1),
    .rst_div_i  (MEM_DIV_C0),
    .tick_o     (mem_tick),
    .cur_div_o  (mem_cur)
  );

  // Clock enable outputs
  assign pix_clk_en_o  = pix_tick;
  assign cam_clk_en_o  = cam_tick;
  assign core_clk_en_o = core_tick;
  assign mem_clk_en_o  = mem_tick;
endmodule // pcc_clock_config

// ### verification/pcc_clock_config_props.sv
// Concurrent checks on the clock configuration block ports
`timescale 1ns/1ps
module pcc_clock_config_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        pll_locked_i,
  input wire logic        pll_tick_i,
  input wire logic        crystal_in_tick_i,
  input wire logic [7:0]  pll_int_o,
  input wire logic        pll_load_o,
  input wire logic        sys_reset_hold_o,
  input wire logic        pix_clk_en_o,
  input wire logic        cam_clk_en_o,
  input wire logic        core_clk_en_o
);
  logic [12:0] hold_len;
  // Length of the current reset hold
  always_ff @(posedge clk_i) begin
    hold_len <= (rst_i || !sys_reset_hold_o) ? 13'h0000 : hold_len + 13'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus handshake
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("stray ack");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000) else $error("dat");
  // Multiplier loading and reset hold
  a_load_pulse: assert property (pll_load_o |=> !pll_load_o) else $error("load held");
  a_mult_on_load: assert property ($changed(pll_int_o) |-> pll_load_o)
    else $error("mult moved");
  a_load_idle: assert property (pll_load_o |-> !sys_reset_hold_o) else $error("busy load");
  a_hold_locked: assert property ($rose(sys_reset_hold_o) |-> $past(pll_locked_i))
    else $error("hold early");
  a_hold_length: assert property ($fell(sys_reset_hold_o) |->
    hold_len == 13'h0100 || hold_len == 13'h0400 || hold_len == 13'h0FF0) else $error("hold len");
  // Divided ticks follow a source tick
  a_core_src: assert property (core_clk_en_o |-> $past(pll_tick_i || crystal_in_tick_i))
    else $error("core tick");
  a_cam_src: assert property (cam_clk_en_o |-> $past(pll_tick_i || crystal_in_tick_i))
    else $error("cam tick");
  c_load: cover property (pll_load_o);
  c_hold: cover property ($rose(sys_reset_hold_o));
  c_write: cover property (wb_ack_o && wb_we_i);
  c_pix: cover property (pix_clk_en_o);
endmodule // pcc_clock_config_props

bind pcc_clock_config pcc_clock_config_props u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pll_locked_i(pll_locked_i), .pll_tick_i(pll_tick_i),
  .crystal_in_tick_i(crystal_in_tick_i), .pll_int_o(pll_int_o), .pll_load_o(pll_load_o),
  .sys_reset_hold_o(sys_reset_hold_o), .pix_clk_en_o(pix_clk_en_o),
  .cam_clk_en_o(cam_clk_en_o), .core_clk_en_o(core_clk_en_o));

// ### verification/tb_pcc_clock_config.sv
// Testbench for the clock configuration block
`timescale 1ns/1ps
module tb_pcc_clock_config;
  import pcc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] adr = 32'h0, dw = 32'h0, dr, w;
  logic [3:0]  sel = 4'h0, bsel = 4'hF;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, lck = 1'b0, pt = 1'b0, xt = 1'b0;
  logic [1:0]  x3 = 2'h0;
  wire  [31:0] dat_o;
  wire  [7:0]  pint, pfrac;
  wire         ack, load, hold, pix, cam, core, mem;
  int          error_cnt = 0, checks_done = 0, loads = 0, k, h, n[4];
  logic [31:0] dv[3] = '{32'h8584833F, 32'h0A0B0C2A, 32'h83008013};
  int          ex[3][3] = '{'{60, 75, 100}, '{40, 50, 67}, '{60, 50, 300}};
  int          hl[4] = '{0, 'h100, 'h400, 'hFF0};
  int          mx[4] = '{150, 75, 100, 100};

  always #20 clk_i = ~clk_i;
  // Source ticks: PLL every second cycle, crystal every third
  always @(posedge clk_i) begin
    pt <= ~pt;
    x3 <= (x3 == 2'h2) ? 2'h0 : x3 + 2'h1;
    xt <= (x3 == 2'h2);
    if (load === 1'b1) loads++;
  end

  pcc_clock_config DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dw),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pll_locked_i(lck), .pll_tick_i(pt), .crystal_in_tick_i(xt),
    .pll_int_o(pint), .pll_frac_o(pfrac), .pll_load_o(load), .sys_reset_hold_o(hold),
    .pix_clk_en_o(pix), .cam_clk_en_o(cam), .core_clk_en_o(core), .mem_clk_en_o(mem));

  // Verdict and reporting
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task cmp(input logic [31:0] g, e, input string m);
    checks_done++;
    if (g !== e) bad(m);
  endtask
  task cnt_cmp(input int g, e, input string m);
    checks_done++;
    if (g < e - 2 || g > e + 2) bad(m);
  endtask
  // One classic Wishbone cycle, held until ack is sampled
  task bus(input logic wr, input logic [31:0] a, d);
    int t;
    cyc <= 1'b1; stb <= 1'b1; we <= wr; adr <= a; dw <= d; sel <= bsel;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      bad("no ack");
      print_verdict;
    end
    dr = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  task rd(input logic [31:0] a, e, input string m);
    bus(1'b0, a, 32'h0);
    cmp(dr, e, m);
  endtask
  // Counts divided ticks over a window
  task meas(input int c);
    n = '{default: 0};
    repeat (c) begin
      @(posedge clk_i);
      n[0] += (pix === 1'b1); n[1] += (cam === 1'b1);
      n[2] += (core === 1'b1); n[3] += (mem === 1'b1);
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_SETUP, 32'h00000000, "setup rst");
    rd(ADDR_DIVIDERS, 32'h00240200, "div rst");
    rd(ADDR_STATUS, 32'h00240210, "status rst");
    bus(1'b1, 32'hBFE7803C, 32'hFFFFFFFF);
    rd(32'hBFE7803C, 32'h0, "unmapped");
    rd(ADDR_SETUP, 32'h0, "setup hit");
    $display("test reset done");
    for (int c = 0; c < 4; c++) begin
      lck <= 1'b0;
      k = loads;
      w = {8'h80, 8'(c), 8'(32 + c), 4'h0, 2'(c), 2'h0};
      bus(1'b1, ADDR_SETUP, w);
      @(posedge clk_i);
      cmp(loads, k + 1, "no load");
      cmp({pint, pfrac}, {8'(32 + c), 8'(c)}, "mult");
      rd(ADDR_SETUP, w, "setup rd");
      rd(ADDR_STATUS, 32'h00240211, "busy");
      lck <= 1'b1;
      h = 0;
      for (int i = 0; i < 4200; i++) begin
        @(posedge clk_i);
        if (hold === 1'b1) h++;
        else if (h > 0) break;
      end
      cmp(h, hl[c], "hold len");
    end
    k = loads;
    bus(1'b1, ADDR_SETUP, 32'h7FFFFFF1);
    @(posedge clk_i);
    cmp(loads, k, "stray load");
    rd(ADDR_SETUP, 32'h00FFFF01, "reserved");
    // Single byte lane: only the integer field moves, the valid bit stays clear
    k = loads;
    bsel = 4'h2;
    bus(1'b1, ADDR_SETUP, 32'hFFFF12FF);
    bsel = 4'hF;
    rd(ADDR_SETUP, 32'h00FF1201, "lane");
    cmp(loads, k, "lane load");
    $display("test pll done");
    for (int r = 0; r < 3; r++) begin
      bus(1'b1, ADDR_DIVIDERS, dv[r]);
      rd(ADDR_DIVIDERS, dv[r] & 32'hFFFFFF3F, "div rd");
      repeat (120) @(posedge clk_i);
      meas(600);
      cnt_cmp(n[0], ex[r][0], "pix rate");
      cnt_cmp(n[1], ex[r][1], "cam rate");
      cnt_cmp(n[2], ex[r][2], "core rate");
    end
    $display("test dividers done");
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, ADDR_SETUP, 32'(m));
      repeat (120) @(posedge clk_i);
      meas(600);
      cnt_cmp(n[3], mx[m], "mem rate");
    end
    $display("test memory done");
    print_verdict;
  end
endmodule // tb_pcc_clock_config
